// [core/pcr_cfg.svh]
// offsets, bit positions and reset values of the pcs host control and status bytes
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// ==========================================================
// host bus offsets
`define PCR_OFF_CTRL_LO    6'h00
`define PCR_OFF_CTRL_HI    6'h01
`define PCR_OFF_STAT_LO    6'h02
`define PCR_OFF_STAT_HI    6'h03

// ==========================================================
// control high byte bit positions
`define PCR_CH_RESET       7
`define PCR_CH_LOOPBACK    6
`define PCR_CH_SPEED0      5
`define PCR_CH_AN_EN       4
`define PCR_CH_PDOWN       3
`define PCR_CH_ISOLATE     2
`define PCR_CH_AN_RESTART  1
`define PCR_CH_DUPLEX      0

// control low byte bit positions
`define PCR_CL_SPEED1      6
`define PCR_CL_UNIDIR      5

// status low byte bit positions
`define PCR_SL_UNIDIR_CAP  7
`define PCR_SL_AN_DONE     5
`define PCR_SL_AN_ABLE     3
`define PCR_SL_LINK        2

// ==========================================================
// fixed values and reset values
`define PCR_SPEED_GBE      2'h2
`define PCR_SPEED_RST      2'h2
`define PCR_AN_EN_RST      1'h1
`define PCR_STAT_HI_FIXED  8'h01
`define PCR_ADV_SPD_HI     11
`define PCR_ADV_SPD_LO     10

`endif

// [core/pcr_link_latch.sv]
// latch-low, clear-on-read holder for the link status bit
`timescale 1ns/1ns
module pcr_link_latch
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  // live link level and read strobe
  input  wire logic link_up_i,
  input  wire logic rd_clr_i,
  // value software sees
  output logic      link_stat_o
);

  logic down_seen_q;
  logic down_seen_d;

  // a drop in the same cycle as the clearing read wins, so no drop is lost
  assign down_seen_d = !link_up_i ? 1'b1 : (rd_clr_i ? 1'b0 : down_seen_q);
  assign link_stat_o = link_up_i & !down_seen_q;

  // ==========================================================
  // sticky record of a link drop
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      down_seen_q <= 1'b0;
    else
      down_seen_q <= down_seen_d;
  end

  // ==========================================================
  // checks
  link_hold_low_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!link_up_i && !rd_clr_i) |=> !link_stat_o)
    else $error("link status did not hold low after a drop");
  link_read_clr_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (link_up_i && rd_clr_i) ##1 link_up_i |-> link_stat_o)
    else $error("link status not restored by read while link up");
  link_drop_cv : cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !link_up_i ##1 link_up_i ##1 rd_clr_i ##1 link_stat_o);

endmodule

// [core/pcr_pkg.sv]
// types shared by the pcs host control and status register bank
package pcr_pkg;
  // two-bit media rate code: 00 10m, 01 100m, 10 1g, 11 reserved
  typedef logic [1:0] pcr_speed_t;
  // one host bus data byte
  typedef logic [7:0] pcr_byte_t;
endpackage

// [core/pcr_regs.sv]
// host bus control and status byte registers of the sgmii / gigabit pcs
`timescale 1ns/1ns
`include "pcr_cfg.svh"
module pcr_regs
#(
  parameter logic UNIDIR_CAP = 1'b1
)
(
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_b_i,
  // byte-wide host bus
  input  wire logic [5:0]         hb_addr_i,
  input  wire pcr_pkg::pcr_byte_t hb_wdata_i,
  input  wire logic               hb_wr_i,
  input  wire logic               hb_rd_i,
  output pcr_pkg::pcr_byte_t      hb_rdata_o,
  // mode and state from the pcs
  input  wire logic               gbe_mode_i,
  input  wire logic [15:0]        adv_ability_i,
  input  wire logic               an_done_i,
  input  wire logic               link_up_i,
  // controls to the pcs
  output pcr_pkg::pcr_speed_t     mii_speed_o,
  output logic                    an_enable_o,
  output logic                    an_restart_o,
  output logic                    chan_reset_o,
  output logic                    power_down_o,
  output logic                    isolate_o,
  output logic                    loopback_o,
  output logic                    unidir_o
);

  // stored control bits
  pcr_pkg::pcr_speed_t speed_q;
  pcr_pkg::pcr_speed_t speed_d;
  logic                an_en_q;
  logic                pdown_q;
  logic                isolate_q;
  logic                loopback_q;
  logic                unidir_q;
  logic                duplex_q;
  logic                restart_q;
  logic                reset_q;
  pcr_pkg::pcr_byte_t  rdata_q;
  pcr_pkg::pcr_byte_t  rdata_d;

  // ==========================================================
  // address decode
  logic                wr_lo;
  logic                wr_hi;
  logic                rd_stat_lo;
  logic                link_stat;
  pcr_pkg::pcr_speed_t speed_rd;
  pcr_pkg::pcr_byte_t  ctrl_lo_rd;
  pcr_pkg::pcr_byte_t  ctrl_hi_rd;
  pcr_pkg::pcr_byte_t  stat_lo_rd;

  assign wr_lo      = hb_wr_i && (hb_addr_i == `PCR_OFF_CTRL_LO);
  assign wr_hi      = hb_wr_i && (hb_addr_i == `PCR_OFF_CTRL_HI);
  assign rd_stat_lo = hb_rd_i && (hb_addr_i == `PCR_OFF_STAT_LO);

  // ==========================================================
  // speed field: two halves in two bytes, frozen at 1g in gigabit mode
  assign speed_d[1] = wr_lo ? hb_wdata_i[`PCR_CL_SPEED1] : speed_q[1];
  assign speed_d[0] = wr_hi ? hb_wdata_i[`PCR_CH_SPEED0] : speed_q[0];
  assign speed_rd   = gbe_mode_i ? `PCR_SPEED_GBE : speed_q;

  // rate follows the advertised ability while negotiation runs
  assign mii_speed_o = an_en_q ? adv_ability_i[`PCR_ADV_SPD_HI:`PCR_ADV_SPD_LO]
                               : speed_rd;

  // ==========================================================
  // control bit storage
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      speed_q    <= `PCR_SPEED_RST;
      an_en_q    <= `PCR_AN_EN_RST;
      pdown_q    <= 1'b0;
      isolate_q  <= 1'b0;
      loopback_q <= 1'b0;
      unidir_q   <= 1'b0;
      duplex_q   <= 1'b0;
    end
    else
    begin
      speed_q <= speed_d;
      if (wr_lo)
        unidir_q <= hb_wdata_i[`PCR_CL_UNIDIR];
      if (wr_hi)
      begin
        an_en_q    <= hb_wdata_i[`PCR_CH_AN_EN];
        pdown_q    <= hb_wdata_i[`PCR_CH_PDOWN];
        isolate_q  <= hb_wdata_i[`PCR_CH_ISOLATE];
        loopback_q <= hb_wdata_i[`PCR_CH_LOOPBACK];
        duplex_q   <= hb_wdata_i[`PCR_CH_DUPLEX];
      end
    end
  end

  // ==========================================================
  // self-clearing commands: high for exactly one cycle after the write
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      restart_q <= 1'b0;
      reset_q   <= 1'b0;
    end
    else
    begin
      restart_q <= wr_hi && hb_wdata_i[`PCR_CH_AN_RESTART];
      reset_q   <= wr_hi && hb_wdata_i[`PCR_CH_RESET];
    end
  end

  // ==========================================================
  // link status latch
  pcr_link_latch u_link
  (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .link_up_i   (link_up_i),
    .rd_clr_i    (rd_stat_lo),
    .link_stat_o (link_stat)
  );

  // ==========================================================
  // read images; stuck bits are constants so writes never reach them
  assign ctrl_lo_rd = {1'b0, speed_rd[1], unidir_q, 5'b0_0000};
  // duplex is read back only; no control output carries it (tx and rx stay split)
  assign ctrl_hi_rd = {reset_q, loopback_q, speed_rd[0], an_en_q,
                       pdown_q, isolate_q, restart_q, duplex_q};
  assign stat_lo_rd = {UNIDIR_CAP, 1'b0, an_done_i, 1'b0,
                       1'b1, link_stat, 2'b00};

  // unmapped offsets read as zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (hb_rd_i)
    begin
      unique case (hb_addr_i)
        `PCR_OFF_CTRL_LO: rdata_d = ctrl_lo_rd;
        `PCR_OFF_CTRL_HI: rdata_d = ctrl_hi_rd;
        `PCR_OFF_STAT_LO: rdata_d = stat_lo_rd;
        `PCR_OFF_STAT_HI: rdata_d = `PCR_STAT_HI_FIXED;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // read data held until the next read
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // ==========================================================
  // outputs
  assign hb_rdata_o   = rdata_q;
  assign an_enable_o  = an_en_q;
  assign an_restart_o = restart_q;
  assign chan_reset_o = reset_q;
  assign power_down_o = pdown_q;
  assign isolate_o    = isolate_q;
  assign loopback_o   = loopback_q;
  assign unidir_o     = unidir_q;

  // ==========================================================
  // checks
  speed_store_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_lo && wr_hi == 1'b0 && !gbe_mode_i) ##1 (!an_en_q && !gbe_mode_i)
      |-> mii_speed_o[1] == $past(hb_wdata_i[`PCR_CL_SPEED1]))
    else $error("sgmii speed bit 1 not stored as written");
  speed_manual_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!an_en_q && !gbe_mode_i) |-> mii_speed_o == speed_q)
    else $error("manual speed not applied with negotiation off");
  speed_adv_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    an_en_q |-> mii_speed_o == adv_ability_i[11:10])
    else $error("negotiated speed not taken from advertised bits");
  speed_split_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (hb_rd_i && hb_addr_i == `PCR_OFF_CTRL_HI) |=> hb_rdata_o[5] == $past(speed_rd[0]))
    else $error("speed bit 0 not at control high bit 5");
  pdown_write_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    wr_hi |=> power_down_o == $past(hb_wdata_i[3]))
    else $error("power down bit not taken from write");
  restart_pulse_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_hi && hb_wdata_i[1]) |=> an_restart_o ##1 (!an_restart_o || $past(wr_hi)))
    else $error("restart did not pulse and self clear");
  gbe_speed_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (gbe_mode_i && !an_en_q) |-> mii_speed_o == 2'b10)
    else $error("gigabit mode speed not fixed at 10");
  reset_pulse_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (wr_hi && hb_wdata_i[7]) |=> chan_reset_o ##1 (!chan_reset_o || $past(wr_hi)))
    else $error("channel reset did not pulse and self clear");
  stuck_bits_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (hb_rd_i && hb_addr_i == `PCR_OFF_STAT_HI) |=> hb_rdata_o == 8'h01)
    else $error("status high stuck bits wrong");
  ctrl_lo_stuck_a : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (hb_rd_i && hb_addr_i == `PCR_OFF_CTRL_LO) |=> hb_rdata_o[7] == 1'b0
      && hb_rdata_o[4:0] == 5'h00)
    else $error("control low stuck bits wrong");

  restart_cv : cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    wr_hi ##1 an_restart_o ##1 !an_restart_o);
  manual_cv  : cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    wr_hi && !hb_wdata_i[4] ##1 !an_en_q && !gbe_mode_i);
  link_rd_cv : cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    rd_stat_lo ##1 hb_rdata_o[2]);

endmodule

// [sim/pcr_regs_test.sv]
// self-checking bench for the pcs host control and status byte registers
`timescale 1ns/1ns
`include "pcr_cfg.svh"
// ==========================================================
// compare helper: counts every check, reports a mismatch at once
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module pcr_regs_test;
  logic                core_clk_i;
  logic                rst_b_i;
  logic [5:0]          hb_addr_i;
  pcr_pkg::pcr_byte_t  hb_wdata_i;
  logic                hb_wr_i;
  logic                hb_rd_i;
  pcr_pkg::pcr_byte_t  hb_rdata_o;
  logic                gbe_mode_i;
  logic [15:0]         adv_ability_i;
  logic                an_done_i;
  logic                link_up_i;
  pcr_pkg::pcr_speed_t mii_speed_o;
  logic                an_enable_o;
  logic                an_restart_o;
  logic                chan_reset_o;
  logic                power_down_o;
  logic                isolate_o;
  logic                loopback_o;
  logic                unidir_o;
  pcr_pkg::pcr_byte_t  rd;
  int                  num_errors;
  int                  compares;

  pcr_regs #(.UNIDIR_CAP(1'b1)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .hb_addr_i(hb_addr_i), .hb_wdata_i(hb_wdata_i), .hb_wr_i(hb_wr_i), .hb_rd_i(hb_rd_i),
    .hb_rdata_o(hb_rdata_o), .gbe_mode_i(gbe_mode_i), .adv_ability_i(adv_ability_i),
    .an_done_i(an_done_i), .link_up_i(link_up_i), .mii_speed_o(mii_speed_o),
    .an_enable_o(an_enable_o), .an_restart_o(an_restart_o), .chan_reset_o(chan_reset_o),
    .power_down_o(power_down_o), .isolate_o(isolate_o), .loopback_o(loopback_o),
    .unidir_o(unidir_o));

  // ==========================================================
  // 20 mhz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // ==========================================================
  // host bus cycles, driven on the falling edge so the rising edge sees stable strobes
  task automatic wr_byte(input logic [5:0] a, input pcr_pkg::pcr_byte_t d);
    @(negedge core_clk_i);
    hb_addr_i  = a;
    hb_wdata_i = d;
    hb_wr_i    = 1'b1;
    @(negedge core_clk_i);
    hb_wr_i    = 1'b0;
  endtask

  // read data is registered, so it is taken one falling edge after the strobe
  task automatic rd_byte(input logic [5:0] a, output pcr_pkg::pcr_byte_t d);
    @(negedge core_clk_i);
    hb_addr_i = a;
    hb_rd_i   = 1'b1;
    @(negedge core_clk_i);
    hb_rd_i   = 1'b0;
    d         = hb_rdata_o;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_byte(`PCR_OFF_CTRL_LO, rd);
    `CHK(rd, 8'h40)
    rd_byte(`PCR_OFF_CTRL_HI, rd);
    `CHK(rd, 8'h10)
    rd_byte(`PCR_OFF_STAT_HI, rd);
    `CHK(rd, 8'h01)
    rd_byte(`PCR_OFF_STAT_LO, rd);
    `CHK(rd, 8'h8c)
    rd_byte(6'h10, rd);
    `CHK(rd, 8'h00)
  endtask

  // negotiation off: every speed code is kept and drives the rate
  task automatic t_sgmii_speed();
    gbe_mode_i    = 1'b0;
    adv_ability_i = 16'h0c00;
    for (int c = 0; c < 4; c++)
    begin
      wr_byte(`PCR_OFF_CTRL_LO, {1'b0, c[1], 6'h00});
      wr_byte(`PCR_OFF_CTRL_HI, {2'b00, c[0], 5'h00});
      `CHK(mii_speed_o, c[1:0])
      rd_byte(`PCR_OFF_CTRL_LO, rd);
      `CHK(rd, {1'b0, c[1], 6'h00})
      rd_byte(`PCR_OFF_CTRL_HI, rd);
      `CHK(rd, {2'b00, c[0], 5'h00})
    end
    wr_byte(`PCR_OFF_CTRL_LO, 8'hff);
    `CHK(unidir_o, 1'b1)
    rd_byte(`PCR_OFF_CTRL_LO, rd);
    `CHK(rd, 8'h60)
  endtask

  // negotiation on: rate follows advertised bits, not the stored code
  task automatic t_an_rate();
    wr_byte(`PCR_OFF_CTRL_LO, 8'h00);
    wr_byte(`PCR_OFF_CTRL_HI, 8'h30);
    `CHK(an_enable_o, 1'b1)
    for (int c = 0; c < 4; c++)
    begin
      adv_ability_i = {4'h0, c[1:0], 10'h000};
      @(negedge core_clk_i);
      `CHK(mii_speed_o, c[1:0])
    end
  endtask

  // gigabit mode pins the speed field at 1g even with negotiation off
  task automatic t_gbe();
    gbe_mode_i = 1'b1;
    wr_byte(`PCR_OFF_CTRL_HI, 8'h00);
    wr_byte(`PCR_OFF_CTRL_LO, 8'h00);
    `CHK(mii_speed_o, `PCR_SPEED_GBE)
    rd_byte(`PCR_OFF_CTRL_LO, rd);
    `CHK(rd, 8'h40)
    rd_byte(`PCR_OFF_CTRL_HI, rd);
    `CHK(rd, 8'h00)
    gbe_mode_i = 1'b0;
  endtask

  // self-clearing pulses, then the plain read/write controls
  task automatic t_ctrl_bits();
    wr_byte(`PCR_OFF_CTRL_HI, 8'h82);
    `CHK(an_restart_o, 1'b1)
    `CHK(chan_reset_o, 1'b1)
    @(negedge core_clk_i);
    `CHK({an_restart_o, chan_reset_o}, 2'b00)
    rd_byte(`PCR_OFF_CTRL_HI, rd);
    `CHK(rd, 8'h00)
    wr_byte(`PCR_OFF_CTRL_HI, 8'h4d);
    `CHK({power_down_o, isolate_o, loopback_o}, 3'b111)
    rd_byte(`PCR_OFF_CTRL_HI, rd);
    `CHK(rd, 8'h4d)
    wr_byte(`PCR_OFF_CTRL_HI, 8'h45);
    `CHK(power_down_o, 1'b0)
    // flipping duplex alone must leave every channel control as it was
    wr_byte(`PCR_OFF_CTRL_HI, 8'h44);
    `CHK({power_down_o, isolate_o, loopback_o, an_enable_o, mii_speed_o}, 6'h18)
  endtask

  // a one-cycle link drop is held low until read, writes to status do nothing
  task automatic t_link();
    an_done_i = 1'b1;
    link_up_i = 1'b0;
    @(negedge core_clk_i);
    link_up_i = 1'b1;
    wr_byte(`PCR_OFF_STAT_LO, 8'h00);
    rd_byte(`PCR_OFF_STAT_LO, rd);
    `CHK(rd, 8'ha8)
    rd_byte(`PCR_OFF_STAT_LO, rd);
    `CHK(rd, 8'hac)
  endtask

  // a reset in mid-run returns every control and the read data to power-on values
  task automatic t_mid_reset();
    wr_byte(`PCR_OFF_CTRL_HI, 8'h4d);
    wr_byte(`PCR_OFF_CTRL_LO, 8'h20);
    an_done_i = 1'b0;
    rst_b_i   = 1'b0;
    @(negedge core_clk_i);
    `CHK(hb_rdata_o, 8'h00)
    `CHK({power_down_o, isolate_o, loopback_o, unidir_o}, 4'h0)
    `CHK({an_enable_o, an_restart_o, chan_reset_o}, 3'h4)
    `CHK(mii_speed_o, adv_ability_i[11:10])
    @(negedge core_clk_i);
    rst_b_i = 1'b1;
    t_reset();
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic summarize();
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the tests need about 105 cycles, this allows 2000
  initial
  begin
    #100000;
    num_errors++;
    summarize();
  end

  // main sequence
  initial
  begin
    num_errors    = 0;
    compares      = 0;
    rst_b_i       = 1'b0;
    hb_addr_i     = 6'h00;
    hb_wdata_i    = 8'h00;
    hb_wr_i       = 1'b0;
    hb_rd_i       = 1'b0;
    gbe_mode_i    = 1'b0;
    adv_ability_i = 16'h0000;
    an_done_i     = 1'b0;
    link_up_i     = 1'b1;
    // seven falling edges so that reset spans seven full rising edges
    repeat (7) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_sgmii_speed();
    t_an_rate();
    t_gbe();
    t_ctrl_bits();
    t_link();
    t_mid_reset();
    summarize();
  end
endmodule
